// ==== hw/dsr_pkg.sv ====
/*
  Shared constants of the burst-of-two DDR static memory pin model.
  Assumes nothing of its surroundings; imported by the lock timer, the memory core, the monitor and the bench, not by the lock interface.
*/
package dsr_pkg;

  // ==========================================================================
  // pin widths
  localparam int PIN_W        = 36;
  localparam int MASK_W       = 4;
  localparam int BYTE_W       = 9;
  localparam int WIDTH_NARROW = 18;
  localparam int WIDTH_WIDE   = 36;
  localparam int ADDR_W_DEF   = 8;

  // ==========================================================================
  // read latency in link clock cycles
  localparam int LAT_NORMAL = 2;
  localparam int LAT_BYPASS = 1;
  localparam int PIPE_N     = LAT_NORMAL + 1;

  // ==========================================================================
  // loop lock timing on the system clock
  localparam int SYS_PERIOD_NS = 10;
  localparam int LOCK_TIME_NS  = 20480;
  localparam int LOCK_CYCLES   = (LOCK_TIME_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;

  // ==========================================================================
  // reset values
  localparam logic RST_LOCKED = 1'b0;
  localparam logic RST_ECHO   = 1'b0;

endpackage

// ==== hw/dsr_lock_if.sv ====
/*
  Carrier of the loop lock level from the lock timer to the memory core.
  Assumes the core resynchronises the level into the link clock domain.
*/
`timescale 1ns/1ps
interface dsr_lock_if;
  logic locked;
  modport timer (output locked);
  modport core  (input  locked);
endinterface

// ==== hw/dsr_dll_timer.sv ====
/*
  Loop bypass pin synchroniser and lock timer on the system clock.
  Assumes the bypass pin is asynchronous to clk_sys.
*/
`timescale 1ns/1ps
module dsr_dll_timer #(
  parameter int LOCK_CYCLES = dsr_pkg::LOCK_CYCLES
) (
  // system
  input  wire logic clk_sys,
  input  wire logic rst_b,
  // loop bypass pin, low bypasses the loop
  input  wire logic loop_bypass_n,
  // lock level out
  dsr_lock_if.timer lock
);
  import dsr_pkg::*;

  localparam int CNT_W = $clog2(LOCK_CYCLES + 1);

  // elaboration refuses a lock time the counter cannot count
  if (LOCK_CYCLES < 1) begin
    $error("LOCK_CYCLES must be at least one");
  end

  // ==========================================================================
  // pin synchroniser
  logic             byp_s1_q;
  logic             byp_s2_q;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic             locked_q;
  logic             locked_d;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      byp_s1_q <= 1'b0;
      byp_s2_q <= 1'b0;
    end else begin
      byp_s1_q <= loop_bypass_n;
      byp_s2_q <= byp_s1_q;
    end
  end

  // ==========================================================================
  // lock timer
  always_comb begin
    cnt_d    = cnt_q;
    locked_d = locked_q;
    if (!byp_s2_q) begin
      cnt_d    = '0;
      locked_d = 1'b0;
    end else if (cnt_q == CNT_W'(LOCK_CYCLES - 1)) begin
      locked_d = 1'b1;
    end else begin
      cnt_d = cnt_q + CNT_W'(1);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q    <= '0;
      locked_q <= RST_LOCKED;
    end else begin
      cnt_q    <= cnt_d;
      locked_q <= locked_d;
    end
  end

  assign lock.locked = locked_q;

endmodule

// ==== hw/dsr_sram.sv ====
/*
  Burst-of-two DDR static memory with separate read and write ports,
  echo strobes, read valid flag and loop bypass latency mode.
  Assumes the complement input strobe is the exact inverse of k_clk, so its
  rising edge is modelled as the falling edge of k_clk; commands come from
  logic clocked by k_clk.
*/
// Notes on behaviour
// - commands on strobe rise, write data on both edges
// - echo strobes edge-matched to read data
// - echo strobes run freely, also when idle
// - bypass low resets loop, drops lock
// - bypass high locks after the lock time
// - loop off gives one-cycle read latency
// - valid flag marks data, aligned to echo
// - address registered only for read or write
// - narrow uses bits 0-17, wide 0-35
// - read data timed to the strobe rises, one beat per cycle
// - read bus drives zero outside accepted read beats
// - low write request starts a write
// - low read request starts a read
// - active-low byte masks qualify each beat
// - normal read beats at two, three cycles
`timescale 1ns/1ps
module dsr_sram #(
  parameter int DATA_W      = dsr_pkg::WIDTH_WIDE,
  parameter int ADDR_W      = dsr_pkg::ADDR_W_DEF,
  parameter int LOCK_CYCLES = dsr_pkg::LOCK_CYCLES
) (
  // system clock and reset
  input  wire logic                       clk_sys,
  input  wire logic                       rst_b,
  // loop bypass pin
  input  wire logic                       loop_bypass_n,
  // input strobe (link clock)
  input  wire logic                       k_clk,
  // commands and write data
  input  wire logic                       read_req_n,
  input  wire logic                       write_req_n,
  input  wire logic [ADDR_W-1:0]          address_pins,
  input  wire logic [dsr_pkg::PIN_W-1:0]  write_bus_inputs,
  input  wire logic [dsr_pkg::MASK_W-1:0] byte_write_mask_n,
  // read side
  output logic      [dsr_pkg::PIN_W-1:0]  read_bus_outputs,
  output logic                            read_valid_flag,
  output logic                            echo_strobe_true,
  output logic                            echo_strobe_inverse
);
  import dsr_pkg::*;

  localparam int NB    = DATA_W / BYTE_W;
  localparam int DEPTH = 2 ** (ADDR_W + 1);

  // elaboration refuses widths the storage and byte merge cannot serve
  if (DATA_W != WIDTH_NARROW && DATA_W != WIDTH_WIDE) begin
    $error("DATA_W must be 18 or 36");
  end
  if (ADDR_W < 1 || ADDR_W > 20) begin
    $error("ADDR_W out of range");
  end

  // ==========================================================================
  // lock timer on the system clock
  dsr_lock_if lock_if ();

  dsr_dll_timer #(
    .LOCK_CYCLES (LOCK_CYCLES)
  ) u_timer (
    .clk_sys       (clk_sys),
    .rst_b         (rst_b),
    .loop_bypass_n (loop_bypass_n),
    .lock          (lock_if.timer)
  );

  // ==========================================================================
  // lock level into the link domain
  logic lock_s1_q;
  logic lock_s2_q;

  always_ff @(posedge k_clk or negedge rst_b) begin
    if (!rst_b) begin
      lock_s1_q <= RST_LOCKED;
      lock_s2_q <= RST_LOCKED;
    end else begin
      lock_s1_q <= lock_if.locked;
      lock_s2_q <= lock_s1_q;
    end
  end

  // ==========================================================================
  // byte merge and storage
  function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old_w,
                                              input logic [DATA_W-1:0] new_w,
                                              input logic [NB-1:0]     mask_n);
    logic [DATA_W-1:0] res;
    res = old_w;
    for (int b = 0; b < NB; b++) begin
      if (!mask_n[b]) begin
        res[b*BYTE_W +: BYTE_W] = new_w[b*BYTE_W +: BYTE_W];
      end
    end
    return res;
  endfunction

  logic [DATA_W-1:0] mem_q [DEPTH];

  // ==========================================================================
  // write capture, strobe rise: address, first beat and its mask
  logic              wv_q;
  logic              wv_d;
  logic [ADDR_W-1:0] wa_q;
  logic [ADDR_W-1:0] wa_d;
  logic [DATA_W-1:0] wd0_q;
  logic [DATA_W-1:0] wd0_d;
  logic [NB-1:0]     wm0_q;
  logic [NB-1:0]     wm0_d;

  always_comb begin
    wv_d  = !write_req_n;
    wa_d  = wa_q;
    wd0_d = wd0_q;
    wm0_d = wm0_q;
    if (!write_req_n) begin
      wa_d  = address_pins;
      wd0_d = write_bus_inputs[DATA_W-1:0];
      wm0_d = byte_write_mask_n[NB-1:0];
    end
  end

  always_ff @(posedge k_clk or negedge rst_b) begin
    if (!rst_b) begin
      wv_q  <= 1'b0;
      wa_q  <= '0;
      wd0_q <= '0;
      wm0_q <= '1;
    end else begin
      wv_q  <= wv_d;
      wa_q  <= wa_d;
      wd0_q <= wd0_d;
      wm0_q <= wm0_d;
    end
  end

  // ==========================================================================
  // write capture, complement strobe rise: second beat and its mask
  logic [DATA_W-1:0] wd1_q;
  logic [DATA_W-1:0] wd1_d;
  logic [NB-1:0]     wm1_q;
  logic [NB-1:0]     wm1_d;

  always_comb begin
    wd1_d = wd1_q;
    wm1_d = wm1_q;
    if (wv_q) begin
      wd1_d = write_bus_inputs[DATA_W-1:0];
      wm1_d = byte_write_mask_n[NB-1:0];
    end
  end

  always_ff @(negedge k_clk or negedge rst_b) begin
    if (!rst_b) begin
      wd1_q <= '0;
      wm1_q <= '1;
    end else begin
      wd1_q <= wd1_d;
      wm1_q <= wm1_d;
    end
  end

  // ==========================================================================
  // array commit one strobe rise after the write request
  logic [ADDR_W:0]   idx0;
  logic [ADDR_W:0]   idx1;
  logic [DATA_W-1:0] cm0;
  logic [DATA_W-1:0] cm1;

  always_comb begin
    idx0 = {wa_q, 1'b0};
    idx1 = {wa_q, 1'b1};
    cm0  = merge(mem_q[idx0], wd0_q, wm0_q);
    cm1  = merge(mem_q[idx1], wd1_q, wm1_q);
  end

  always_ff @(posedge k_clk) begin
    if (wv_q) begin
      mem_q[idx0] <= cm0;
      mem_q[idx1] <= cm1;
    end
  end

  // a read launched on the commit edge sees the pending write
  function automatic logic [DATA_W-1:0] rd_word(input logic [ADDR_W-1:0] a,
                                                input logic              beat);
    logic [DATA_W-1:0] res;
    res = mem_q[{a, beat}];
    if (wv_q && a == wa_q) begin
      res = beat ? cm1 : cm0;
    end
    return res;
  endfunction

  // ==========================================================================
  // read request pipeline
  logic [PIPE_N-1:0] pv_q;
  logic [PIPE_N-1:0] pv_d;
  logic [ADDR_W-1:0] pa_q [PIPE_N];
  logic [ADDR_W-1:0] pa_d [PIPE_N];

  always_comb begin
    pv_d[0] = !read_req_n;
    pa_d[0] = read_req_n ? pa_q[0] : address_pins;
    for (int i = 1; i < PIPE_N; i++) begin
      pv_d[i] = pv_q[i-1];
      pa_d[i] = pa_q[i-1];
    end
  end

  always_ff @(posedge k_clk or negedge rst_b) begin
    if (!rst_b) begin
      pv_q <= '0;
      for (int i = 0; i < PIPE_N; i++) begin
        pa_q[i] <= '0;
      end
    end else begin
      pv_q <= pv_d;
      for (int i = 0; i < PIPE_N; i++) begin
        pa_q[i] <= pa_d[i];
      end
    end
  end

  // ==========================================================================
  // read output beats
  logic              lat_short;
  logic              b0_v;
  logic              b1_v;
  logic [ADDR_W-1:0] b0_a;
  logic [ADDR_W-1:0] b1_a;
  logic [DATA_W-1:0] q_q;
  logic [DATA_W-1:0] q_d;
  logic              vld_q;
  logic              vld_d;

  always_comb begin
    lat_short = !lock_s2_q;
    b0_v = lat_short ? pv_q[LAT_BYPASS-1] : pv_q[LAT_NORMAL-1];
    b0_a = lat_short ? pa_q[LAT_BYPASS-1] : pa_q[LAT_NORMAL-1];
    b1_v = lat_short ? pv_q[LAT_BYPASS]   : pv_q[LAT_NORMAL];
    b1_a = lat_short ? pa_q[LAT_BYPASS]   : pa_q[LAT_NORMAL];
    q_d   = '0;
    vld_d = 1'b0;
    if (b1_v) begin
      q_d   = rd_word(b1_a, 1'b1);
      vld_d = 1'b1;
    end else if (b0_v) begin
      q_d   = rd_word(b0_a, 1'b0);
      vld_d = 1'b1;
    end
  end

  // launched on the strobe rise, the same edge the echo strobe rises on
  always_ff @(posedge k_clk or negedge rst_b) begin
    if (!rst_b) begin
      q_q   <= '0;
      vld_q <= 1'b0;
    end else begin
      q_q   <= q_d;
      vld_q <= vld_d;
    end
  end

  assign read_bus_outputs = PIN_W'(q_q);
  assign read_valid_flag  = vld_q;

  // ==========================================================================
  // free-running echo strobes
  logic ep_q;
  logic ep_d;
  logic en_q;
  logic en_d;

  always_comb begin
    ep_d = !ep_q;
    en_d = ep_q;
  end

  always_ff @(posedge k_clk or negedge rst_b) begin
    if (!rst_b) begin
      ep_q <= RST_ECHO;
    end else begin
      ep_q <= ep_d;
    end
  end

  always_ff @(negedge k_clk or negedge rst_b) begin
    if (!rst_b) begin
      en_q <= RST_ECHO;
    end else begin
      en_q <= en_d;
    end
  end

  // rises on each strobe rise, falls on each strobe fall
  assign echo_strobe_true    = ep_q ^ en_q;
  assign echo_strobe_inverse = !(ep_q ^ en_q);

endmodule

// ==== test/dsr_sram_monitor.sv ====
/*
  Concurrent checks on the pins of the burst-of-two memory.
  Assumes it is bound into dsr_sram and sees only its ports.
*/
`timescale 1ns/1ps
module dsr_sram_monitor #(
  parameter int DATA_W = dsr_pkg::WIDTH_WIDE
) (
  // link clock and reset
  input wire logic                      k_clk,
  input wire logic                      rst_b,
  // watched pins
  input wire logic                      read_req_n,
  input wire logic [dsr_pkg::PIN_W-1:0] read_bus_outputs,
  input wire logic                      read_valid_flag,
  input wire logic                      echo_strobe_true,
  input wire logic                      echo_strobe_inverse
);
  import dsr_pkg::*;
  // ==========================================================
  // properties
  default clocking @(posedge k_clk); endclocking
  default disable iff (!rst_b);

  a_echo_low_rise: assert property (!echo_strobe_true && echo_strobe_inverse)
    else $error("echo strobes not low before a strobe rise");
  a_echo_high_fall: assert property (@(negedge k_clk) $past(rst_b) |->
    echo_strobe_true && !echo_strobe_inverse)
    else $error("echo strobes not high before a strobe fall");
  a_read_answer: assert property (!read_req_n |-> ##3 read_valid_flag)
    else $error("read got no beat in time");
  a_no_spurious: assert property (read_valid_flag |-> !$past(read_req_n, 2) ||
    !$past(read_req_n, 3) || !$past(read_req_n, 4))
    else $error("valid beat without a read");
  a_idle_bus: assert property (!read_valid_flag |-> read_bus_outputs == '0)
    else $error("read bus busy without a beat");
  a_narrow_bits: assert property ((read_bus_outputs >> DATA_W) == '0)
    else $error("unused read bits driven");
  a_pair_start: assert property ($rose(read_valid_flag) |=> read_valid_flag)
    else $error("single beat burst");
  a_pair_len: assert property ($fell(read_valid_flag) |-> $past(read_valid_flag, 2))
    else $error("valid flag too short");
endmodule

bind dsr_sram dsr_sram_monitor #(.DATA_W(DATA_W)) u_mon (.k_clk, .rst_b, .read_req_n,
  .read_bus_outputs, .read_valid_flag, .echo_strobe_true, .echo_strobe_inverse);

// ==== test/dsr_ctl_model.sv ====
/*
  Memory controller model: makes the input strobe and drives commands.
  Assumes the complement strobe is the falling edge of k_clk.
*/
`timescale 1ns/1ps
module dsr_ctl_model (
  // link clock and commands
  output logic        k_clk,
  output logic        read_req_n,
  output logic        write_req_n,
  output logic [7:0]  address_pins,
  output logic [35:0] write_bus_inputs,
  output logic [3:0]  byte_write_mask_n,
  // read side seen
  input  wire logic [35:0] read_bus_outputs,
  input  wire logic        read_valid_flag,
  input  wire logic        echo_strobe_true
);
  // 64 ns period, far below the bypass speed limit
  initial begin
    k_clk = 1'b0;
    read_req_n = 1'b1;
    write_req_n = 1'b1;
    address_pins = 8'h00;
    write_bus_inputs = 36'h0;
    byte_write_mask_n = 4'hF;
    #1;
    forever begin
      k_clk = ~k_clk;
      #32;
    end
  end

  // one strobe cycle; beat0 set off the fall, beat1 set on the rise
  task automatic cmd(input logic r, w, input logic [7:0] a,
    input logic [35:0] d0, d1, input logic [3:0] m0, m1, output logic [37:0] seen);
    @(negedge k_clk);
    #1;
    seen = {echo_strobe_true, read_valid_flag, read_bus_outputs};
    read_req_n <= r;
    write_req_n <= w;
    address_pins <= (r & w) ? ~address_pins : a;
    write_bus_inputs <= w ? ~write_bus_inputs : d0;
    byte_write_mask_n <= w ? ~byte_write_mask_n : m0;
    @(posedge k_clk);
    write_bus_inputs <= w ? ~write_bus_inputs : d1;
    byte_write_mask_n <= w ? ~byte_write_mask_n : m1;
  endtask
endmodule

// ==== test/dsr_sram_tb_top.sv ====
/*
  Self-checking bench for the narrow memory variant.
  Assumes the controller model drives the link pins.
*/
`timescale 1ns/1ps
module dsr_sram_tb_top;
  import dsr_pkg::*;
  logic              clk_sys = 1'b0;
  logic              rst_b, loop_bypass_n, k_clk, read_req_n, write_req_n;
  logic [7:0]        address_pins;
  logic [PIN_W-1:0]  write_bus_inputs, read_bus_outputs;
  logic [MASK_W-1:0] byte_write_mask_n;
  logic              read_valid_flag, echo_strobe_true, echo_strobe_inverse;
  logic [PIN_W-1:0]  mem [0:511];
  logic [PIN_W:0]    exp_at [0:127];
  int                fails, num_checks, cyc, lat;
  int                cycles = 0;

  dsr_sram #(.DATA_W(WIDTH_NARROW), .LOCK_CYCLES(8)) dut (.clk_sys, .rst_b, .loop_bypass_n,
    .k_clk, .read_req_n, .write_req_n, .address_pins, .write_bus_inputs,
    .byte_write_mask_n, .read_bus_outputs, .read_valid_flag, .echo_strobe_true,
    .echo_strobe_inverse);
  dsr_ctl_model ctl (.k_clk, .read_req_n, .write_req_n, .address_pins, .write_bus_inputs,
    .byte_write_mask_n, .read_bus_outputs, .read_valid_flag, .echo_strobe_true);

  always #5 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 2000) begin
      fails++;
      report_and_stop();
    end
  end

  // ==========================================================
  // helpers
  task automatic chk(input logic [37:0] got, want);
    num_checks++;
    if (got !== want) begin
      fails++;
      $display("[FAIL] t=%0t got=%h want=%h", $time, got, want);
    end
  endtask

  task automatic op(input logic r, w, input logic [7:0] a,
    input logic [35:0] d0, d1, input logic [1:0] m0, m1);
    logic [37:0] s;
    logic [36:0] e;
    ctl.cmd(r, w, a, d0, d1, {2'b11, m0}, {2'b11, m1}, s);
    e = exp_at[cyc];
    chk(s, {1'b0, e});
    if (!r) begin
      exp_at[cyc+lat+1] = {1'b1, mem[{a, 1'b0}]};
      exp_at[cyc+lat+2] = {1'b1, mem[{a, 1'b1}]};
    end
    for (int b = 0; b < 2; b++) begin
      if (!w && !m0[b]) mem[{a, 1'b0}][9*b+:9] = d0[9*b+:9];
      if (!w && !m1[b]) mem[{a, 1'b1}][9*b+:9] = d1[9*b+:9];
    end
    cyc++;
  endtask

  task automatic idle(input int n);
    repeat (n) op(1'b1, 1'b1, 8'h00, 36'h0, 36'h0, 2'b11, 2'b11);
  endtask

  // ==========================================================
  // scenarios
  task automatic t_bypass();
    lat = LAT_BYPASS;
    op(1'b1, 1'b0, 8'h03, 36'hFFFC1_2345, 36'h0000A_BCDE, 2'b00, 2'b00);
    idle(1);
    op(1'b0, 1'b1, 8'h03, 36'h0, 36'h0, 2'b11, 2'b11);
    idle(4);
    $display("test bypass done");
  endtask

  task automatic t_lock();
    @(posedge clk_sys);
    loop_bypass_n <= 1'b1;
    idle(20);
    lat = LAT_NORMAL;
    op(1'b1, 1'b0, 8'h05, 36'h3_1111, 36'h2_2222, 2'b00, 2'b00);
    op(1'b1, 1'b0, 8'h05, 36'h0_ABCD, 36'h1_5678, 2'b10, 2'b01);
    idle(1);
    op(1'b0, 1'b1, 8'h03, 36'h0, 36'h0, 2'b11, 2'b11);
    idle(1);
    op(1'b0, 1'b1, 8'h05, 36'h0, 36'h0, 2'b11, 2'b11);
    idle(5);
    $display("test lock done");
  endtask

  task automatic t_drop();
    @(posedge clk_sys);
    loop_bypass_n <= 1'b0;
    idle(4);
    lat = LAT_BYPASS;
    op(1'b0, 1'b1, 8'h05, 36'h0, 36'h0, 2'b11, 2'b11);
    idle(4);
    $display("test drop done");
  endtask

  task automatic report_and_stop();
    $display("checks=%0d fails=%0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    rst_b = 1'b0;
    loop_bypass_n = 1'b0;
    fails = 0;
    num_checks = 0;
    cyc = 0;
    lat = LAT_BYPASS;
    foreach (mem[i]) mem[i] = '0;
    foreach (exp_at[i]) exp_at[i] = '0;
    repeat (6) @(posedge clk_sys);
    rst_b <= 1'b1;
    t_bypass();
    t_lock();
    t_drop();
    report_and_stop();
  end
endmodule
